/* logic/cdr_pkg.sv */
`default_nettype none
package cdr_pkg;
    // ----------------------------------------
    // register indices and byte addresses
    // ----------------------------------------
    localparam logic [7:0] CDR_IDX_REC_SEL = 8'h3D;
    localparam logic [7:0] CDR_IDX_CORE_CFG = 8'h3E;
    localparam logic [7:0] CDR_IDX_PLAY_SETUP = 8'h3F;
    localparam logic [11:0] CDR_ADDR_REC_SEL = {2'b00, CDR_IDX_REC_SEL, 2'b00};
    localparam logic [11:0] CDR_ADDR_CORE_CFG = {2'b00, CDR_IDX_CORE_CFG, 2'b00};
    localparam logic [11:0] CDR_ADDR_PLAY_SETUP = {2'b00, CDR_IDX_PLAY_SETUP, 2'b00};

    // ----------------------------------------
    // record processing select field
    // ----------------------------------------
    localparam int CDR_REC_SEL_W = 5;
    localparam logic [4:0] CDR_REC_SEL_CORE = 5'h00;
    localparam logic [4:0] CDR_REC_SEL_MAX = 5'h12;
    localparam logic [4:0] CDR_REC_SEL_RST = 5'h01;

    // ----------------------------------------
    // core configuration bits
    // ----------------------------------------
    localparam int CDR_CFG_REC_AUX_A = 6;
    localparam int CDR_CFG_REC_AUX_B = 5;
    localparam int CDR_CFG_REC_KEEP = 4;
    localparam int CDR_CFG_PLAY_AUX_A = 2;
    localparam int CDR_CFG_PLAY_AUX_B = 1;
    localparam int CDR_CFG_PLAY_KEEP = 0;
    localparam logic [7:0] CDR_CFG_RW_MASK = 8'h77;
    localparam logic [7:0] CDR_CFG_RST = 8'h00;

    // ----------------------------------------
    // playback setup fields
    // ----------------------------------------
    localparam int CDR_PS_PWR_L = 7;
    localparam int CDR_PS_PWR_R = 6;
    localparam int CDR_PS_SRC_L = 4;
    localparam int CDR_PS_SRC_R = 2;
    localparam int CDR_PS_STEP = 0;
    localparam logic [7:0] CDR_PS_RST = 8'h14;

    typedef enum logic [1:0] {
        CDR_SRC_OFF = 2'h0,
        CDR_SRC_SAME = 2'h1,
        CDR_SRC_OTHER = 2'h2,
        CDR_SRC_MONO = 2'h3
    } cdr_src_e;

    typedef enum logic [1:0] {
        CDR_STEP_ONE_WC = 2'h0,
        CDR_STEP_TWO_WC = 2'h1,
        CDR_STEP_NOW = 2'h2,
        CDR_STEP_RSVD = 2'h3
    } cdr_step_e;
endpackage
`default_nettype wire

/* logic/cdr_icount.sv */
`timescale 1ns/1ns
`default_nettype none
module cdr_icount #(
    parameter int PC_W = 10
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic run_i,
    input wire logic keep_i,
    input wire logic frame_start_i,
    output logic [PC_W-1:0] pc_o
);
    logic [PC_W-1:0] pc_ff;

    // ----------------------------------------
    // instruction counter
    // ----------------------------------------
    // idle core sits at zero so it starts clean when selected
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pc_ff <= '0;
        end else if (!run_i) begin
            pc_ff <= '0;
        end else if (frame_start_i && !keep_i) begin
            pc_ff <= '0;
        end else begin
            pc_ff <= pc_ff + 1'b1; // wraps, program length is the core's business
        end
    end

    assign pc_o = pc_ff;

    frame_clear_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        run_i && frame_start_i && !keep_i |=> pc_ff == '0)
        else $error("counter not cleared at frame start");
    keep_run_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        run_i && keep_i ##1 run_i |-> pc_ff == $past(pc_ff) + 1'b1)
        else $error("counter did not run across frame");
endmodule
`default_nettype wire

/* logic/cdr_srcmux.sv */
`timescale 1ns/1ns
`default_nettype none
module cdr_srcmux
    import cdr_pkg::*;
#(
    parameter int SW = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic strobe_i,
    input wire logic pwr_i,
    input wire logic [1:0] sel_i,
    input wire logic signed [SW-1:0] same_i,
    input wire logic signed [SW-1:0] other_i,
    output logic signed [SW-1:0] sample_o
);
    logic signed [SW-1:0] sample_ff;
    logic signed [SW:0] sum;

    // ----------------------------------------
    // mono mix and selection
    // ----------------------------------------
    // one extra bit keeps the sum exact before halving
    assign sum = {same_i[SW-1], same_i} + {other_i[SW-1], other_i};

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sample_ff <= '0;
        end else if (!pwr_i) begin
            sample_ff <= '0; // powered down channel carries silence
        end else if (strobe_i) begin
            case (cdr_src_e'(sel_i))
                CDR_SRC_OFF: sample_ff <= '0;
                CDR_SRC_SAME: sample_ff <= same_i;
                CDR_SRC_OTHER: sample_ff <= other_i;
                CDR_SRC_MONO: sample_ff <= sum[SW:1];
                default: sample_ff <= '0;
            endcase
        end
    end

    assign sample_o = sample_ff;

    mono_avg_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        pwr_i && strobe_i && sel_i == 2'h3 |=> sample_ff == $past(sum[SW:1]))
        else $error("mono mix is not the average");
    src_off_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        strobe_i && sel_i == 2'h0 |=> sample_ff == '0)
        else $error("disabled source not silent");
endmodule
`default_nettype wire

/* logic/cdr_regs.sv */
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - record select 0 picks programmable core, 1..18 fixed blocks, above reserved.
// - record select resets to one, the first fixed record block.
// - record core condition bits A (bit 6) and B (bit 5), reset zero.
// - record counter clears each frame when bit 4 is zero, else runs on.
// - playback core condition bits A (bit 2) and B (bit 1), reset zero.
// - playback counter clears each frame when bit 0 is zero, else runs on.
// - configuration bits 7 and 3 read zero; software writes only zero.
// - setup bit 7 powers left playback channel, reset off.
// - setup bit 6 powers right playback channel, reset off.
// - left source: off, left, right or mono mix.
// - right source: off, right, left or mono mix.
// - both source fields reset to same-side channel.
// - soft-step: every word clock, every second, immediate; code 3 reserved.
// - with power config zero, playback core follows playback channel power.
module cdr_regs
    import cdr_pkg::*;
#(
    parameter int SW = 16,
    parameter int PC_W = 10
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rec_frame_i,
    input wire logic play_frame_i,
    input wire logic play_core_sel_i,
    input wire logic play_core_pwr_cfg_i,
    input wire logic rec_chan_pwr_i,
    input wire logic aif_strobe_i,
    input wire logic signed [SW-1:0] aif_left_i,
    input wire logic signed [SW-1:0] aif_right_i,
    input wire logic vol_wclk_i,
    input wire logic signed [7:0] vol_tgt_left_i,
    input wire logic signed [7:0] vol_tgt_right_i,
    output logic [4:0] rec_sel_o,
    output logic rec_core_en_o,
    output logic rec_aux_a_o,
    output logic rec_aux_b_o,
    output logic [PC_W-1:0] rec_pc_o,
    output logic play_aux_a_o,
    output logic play_aux_b_o,
    output logic [PC_W-1:0] play_pc_o,
    output logic play_core_pwr_o,
    output logic play_left_pwr_o,
    output logic play_right_pwr_o,
    output logic signed [SW-1:0] play_left_o,
    output logic signed [SW-1:0] play_right_o,
    output logic signed [7:0] vol_left_o,
    output logic signed [7:0] vol_right_o
);
    // ----------------------------------------
    // address decode
    // ----------------------------------------
    function automatic logic [1:0] reg_hit(input logic [11:0] addr);
        logic [1:0] idx;
        idx = 2'h3;
        if (addr == CDR_ADDR_REC_SEL) idx = 2'h0;
        else if (addr == CDR_ADDR_CORE_CFG) idx = 2'h1;
        else if (addr == CDR_ADDR_PLAY_SETUP) idx = 2'h2;
        return idx;
    endfunction

    logic [4:0] rec_sel_ff;
    logic [7:0] cfg_ff;
    logic [7:0] ps_ff;
    logic [31:0] rdata_ff;
    logic [1:0] hit;
    logic wr_acc;
    logic [4:0] wr_sel;
    logic [1:0] wr_step;

    assign hit = reg_hit(paddr_i);
    assign wr_acc = psel_i && penable_i && pwrite_i;
    assign wr_sel = pwdata_i[4:0];
    assign wr_step = pwdata_i[CDR_PS_STEP +: 2];

    // zero wait states; unmapped addresses answer with an error
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && (hit == 2'h3);

    // ----------------------------------------
    // record processing select register
    // ----------------------------------------
    // reserved codes are dropped so the path never runs an absent block
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rec_sel_ff <= CDR_REC_SEL_RST;
        end else if (wr_acc && hit == 2'h0 && wr_sel <= CDR_REC_SEL_MAX) begin
            rec_sel_ff <= wr_sel;
        end
    end

    // ----------------------------------------
    // core configuration register
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_ff <= CDR_CFG_RST;
        end else if (wr_acc && hit == 2'h1) begin
            cfg_ff <= pwdata_i[7:0] & CDR_CFG_RW_MASK;
        end
    end

    // ----------------------------------------
    // playback setup register
    // ----------------------------------------
    // a reserved soft-step code leaves the old mode in place
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            ps_ff <= CDR_PS_RST;
        end else if (wr_acc && hit == 2'h2) begin
            ps_ff[7:2] <= pwdata_i[7:2];
            if (wr_step != CDR_STEP_RSVD) begin
                ps_ff[CDR_PS_STEP +: 2] <= wr_step;
            end
        end
    end

    // ----------------------------------------
    // read data, captured in the setup phase
    // ----------------------------------------
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rdata_ff <= '0;
        end else if (psel_i && !penable_i) begin
            case (hit)
                2'h0: rdata_ff <= {27'h0, rec_sel_ff};
                2'h1: rdata_ff <= {24'h0, cfg_ff};
                2'h2: rdata_ff <= {24'h0, ps_ff};
                default: rdata_ff <= '0;
            endcase
        end
    end

    assign prdata_o = rdata_ff;

    // ----------------------------------------
    // core controls
    // ----------------------------------------
    assign rec_sel_o = rec_sel_ff;
    assign rec_core_en_o = (rec_sel_ff == CDR_REC_SEL_CORE);
    assign rec_aux_a_o = cfg_ff[CDR_CFG_REC_AUX_A];
    assign rec_aux_b_o = cfg_ff[CDR_CFG_REC_AUX_B];
    assign play_aux_a_o = cfg_ff[CDR_CFG_PLAY_AUX_A];
    assign play_aux_b_o = cfg_ff[CDR_CFG_PLAY_AUX_B];
    assign play_left_pwr_o = ps_ff[CDR_PS_PWR_L];
    assign play_right_pwr_o = ps_ff[CDR_PS_PWR_R];

    // playback core either follows its own channels or the record channel
    assign play_core_pwr_o = play_core_pwr_cfg_i ? rec_chan_pwr_i
                           : (play_left_pwr_o || play_right_pwr_o);

    cdr_icount #(
        .PC_W(PC_W)
    ) u_rec_pc (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .run_i(rec_core_en_o),
        .keep_i(cfg_ff[CDR_CFG_REC_KEEP]),
        .frame_start_i(rec_frame_i),
        .pc_o(rec_pc_o)
    );

    cdr_icount #(
        .PC_W(PC_W)
    ) u_play_pc (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .run_i(play_core_sel_i && play_core_pwr_o),
        .keep_i(cfg_ff[CDR_CFG_PLAY_KEEP]),
        .frame_start_i(play_frame_i),
        .pc_o(play_pc_o)
    );

    // ----------------------------------------
    // playback source routing
    // ----------------------------------------
    cdr_srcmux #(
        .SW(SW)
    ) u_left_src (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .strobe_i(aif_strobe_i),
        .pwr_i(play_left_pwr_o),
        .sel_i(ps_ff[CDR_PS_SRC_L +: 2]),
        .same_i(aif_left_i),
        .other_i(aif_right_i),
        .sample_o(play_left_o)
    );

    cdr_srcmux #(
        .SW(SW)
    ) u_right_src (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .strobe_i(aif_strobe_i),
        .pwr_i(play_right_pwr_o),
        .sel_i(ps_ff[CDR_PS_SRC_R +: 2]),
        .same_i(aif_right_i),
        .other_i(aif_left_i),
        .sample_o(play_right_o)
    );

    // ----------------------------------------
    // volume soft-stepping
    // ----------------------------------------
    logic half_ff;
    logic step_en;
    logic [1:0] step_mode;
    logic signed [7:0] vol_tgt [2];
    logic signed [7:0] vol_ff [2];

    assign step_mode = ps_ff[CDR_PS_STEP +: 2];
    assign vol_tgt[0] = vol_tgt_left_i;
    assign vol_tgt[1] = vol_tgt_right_i;

    // divides word clocks by two for the slower stepping mode
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            half_ff <= 1'b0;
        end else if (vol_wclk_i) begin
            half_ff <= !half_ff;
        end
    end

    assign step_en = vol_wclk_i && ((step_mode == CDR_STEP_ONE_WC)
                   || (step_mode == CDR_STEP_TWO_WC && half_ff));

    for (genvar ch = 0; ch < 2; ch++) begin : g_vol
        // one half-dB step per enable avoids zipper noise on big jumps
        always_ff @(posedge ref_clk_i or posedge reset_i) begin
            if (reset_i) begin
                vol_ff[ch] <= '0;
            end else if (step_mode == CDR_STEP_NOW) begin
                vol_ff[ch] <= vol_tgt[ch];
            end else if (step_en && vol_ff[ch] < vol_tgt[ch]) begin
                vol_ff[ch] <= vol_ff[ch] + 8'sh01;
            end else if (step_en && vol_ff[ch] > vol_tgt[ch]) begin
                vol_ff[ch] <= vol_ff[ch] - 8'sh01;
            end
        end
    end

    assign vol_left_o = vol_ff[0];
    assign vol_right_o = vol_ff[1];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    sel_reserved_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rec_sel_ff <= CDR_REC_SEL_MAX)
        else $error("record select holds a reserved code");
    sel_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_acc && hit == 2'h0 && wr_sel <= CDR_REC_SEL_MAX |=> rec_sel_ff == $past(wr_sel))
        else $error("record select write lost");
    cfg_reserved_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        psel_i && !penable_i && hit == 2'h1 |=> rdata_ff[7] == 1'b0 && rdata_ff[3] == 1'b0)
        else $error("reserved configuration bits read nonzero");
    aux_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_acc && hit == 2'h1 |=> rec_aux_a_o == $past(pwdata_i[6]) && play_aux_b_o == $past(pwdata_i[1]))
        else $error("condition bits not taken from write");
    step_keep_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        step_mode != CDR_STEP_RSVD)
        else $error("soft-step holds reserved code");
    core_pwr_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !play_core_pwr_cfg_i && !ps_ff[7] && !ps_ff[6] |-> !play_core_pwr_o)
        else $error("playback core powered with channels down");
    vol_now_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        step_mode == CDR_STEP_NOW ##1 step_mode == CDR_STEP_NOW |-> vol_ff[0] == $past(vol_tgt[0]))
        else $error("immediate volume not applied");
    vol_hold_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !vol_wclk_i && step_mode != CDR_STEP_NOW ##1 step_mode != CDR_STEP_NOW
        |-> vol_ff[1] == $past(vol_ff[1]))
        else $error("volume moved without word clock");
    pwr_write_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_acc && hit == 2'h2 |=> play_left_pwr_o == $past(pwdata_i[7]) && play_right_pwr_o == $past(pwdata_i[6]))
        else $error("channel power not taken from write");
    sel_drop_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_acc && hit == 2'h0 && wr_sel > CDR_REC_SEL_MAX |=> $stable(rec_sel_ff))
        else $error("reserved record select code stored");
    aux_play_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_acc && hit == 2'h1 |=> play_aux_a_o == $past(pwdata_i[2]) && rec_aux_b_o == $past(pwdata_i[5]))
        else $error("other condition bits not taken from write");
    left_route_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        aif_strobe_i && play_left_pwr_o && ps_ff[CDR_PS_SRC_L +: 2] == 2'h2 |=> play_left_o == $past(aif_right_i))
        else $error("left channel not fed from right source");
    right_route_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        aif_strobe_i && play_right_pwr_o && ps_ff[CDR_PS_SRC_R +: 2] == 2'h2 |=> play_right_o == $past(aif_left_i))
        else $error("right channel not fed from left source");
    step_one_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        vol_wclk_i && step_mode == CDR_STEP_ONE_WC && vol_ff[1] > vol_tgt[1]
        |=> vol_ff[1] == $past(vol_ff[1]) - 8'sh01)
        else $error("volume did not step down by one");
endmodule
`default_nettype wire

/* tb/cdr_regs_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench
    import cdr_pkg::*;
;
    // ----------------------------------------
    // stimulus, observation and design hookup
    // ----------------------------------------
    logic ref_clk_i, reset_i, psel_i, penable_i, pwrite_i, pready_o, pslverr_o;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic rec_frame_i, play_frame_i, play_core_sel_i, play_core_pwr_cfg_i, rec_chan_pwr_i, aif_strobe_i;
    logic [15:0] aif_left_i, aif_right_i, play_left_o, play_right_o;
    logic vol_wclk_i, rec_core_en_o, rec_aux_a_o, rec_aux_b_o, play_aux_a_o, play_aux_b_o;
    logic [7:0] vol_tgt_left_i, vol_tgt_right_i, vol_left_o, vol_right_o;
    logic [4:0] rec_sel_o;
    logic [9:0] rec_pc_o, play_pc_o;
    logic play_core_pwr_o, play_left_pwr_o, play_right_pwr_o;
    int err_count, n_checks, cyc;

    cdr_regs #(.SW(16), .PC_W(10)) i_dut (
        .ref_clk_i(ref_clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .rec_frame_i(rec_frame_i), .play_frame_i(play_frame_i),
        .play_core_sel_i(play_core_sel_i), .play_core_pwr_cfg_i(play_core_pwr_cfg_i),
        .rec_chan_pwr_i(rec_chan_pwr_i), .aif_strobe_i(aif_strobe_i), .aif_left_i(aif_left_i),
        .aif_right_i(aif_right_i), .vol_wclk_i(vol_wclk_i), .vol_tgt_left_i(vol_tgt_left_i),
        .vol_tgt_right_i(vol_tgt_right_i), .rec_sel_o(rec_sel_o), .rec_core_en_o(rec_core_en_o),
        .rec_aux_a_o(rec_aux_a_o), .rec_aux_b_o(rec_aux_b_o), .rec_pc_o(rec_pc_o),
        .play_aux_a_o(play_aux_a_o), .play_aux_b_o(play_aux_b_o), .play_pc_o(play_pc_o),
        .play_core_pwr_o(play_core_pwr_o), .play_left_pwr_o(play_left_pwr_o),
        .play_right_pwr_o(play_right_pwr_o), .play_left_o(play_left_o), .play_right_o(play_right_o),
        .vol_left_o(vol_left_o), .vol_right_o(vol_right_o)
    );

    // 50 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // cycle count doubles as counter reference and hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            err_count++;
            close_out();
        end
    end

    // ----------------------------------------
    // shared tasks and expectations
    // ----------------------------------------
    task automatic close_out();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; waits on pready, never assumes a latency
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic er);
        @(posedge ref_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= wd;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic er;
        apb(1'b1, a, {24'h000000, d}, rd, er);
    endtask

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic er;
        apb(1'b0, a, 32'h00000000, rd, er);
        chk(name, exp, rd);
    endtask

    // frame pulse on both paths, sampled by the following edge
    task automatic pulse_frame();
        @(posedge ref_clk_i);
        rec_frame_i <= 1'b1;
        play_frame_i <= 1'b1;
        @(posedge ref_clk_i);
        rec_frame_i <= 1'b0;
        play_frame_i <= 1'b0;
        #1;
    endtask

    task automatic wclk();
        @(posedge ref_clk_i);
        vol_wclk_i <= 1'b1;
        @(posedge ref_clk_i);
        vol_wclk_i <= 1'b0;
        #1;
    endtask

    // mono mix uses a wider sum so full-scale inputs cannot wrap
    function automatic logic [15:0] exp_src(input logic [1:0] sel, input logic p, input logic [15:0] s,
                                            input logic [15:0] o);
        logic signed [16:0] sum;
        sum = $signed({s[15], s}) + $signed({o[15], o});
        if (!p) begin
            return 16'h0000;
        end
        case (sel)
            2'b00: return 16'h0000;
            2'b01: return s;
            2'b10: return o;
            default: return sum[16:1];
        endcase
    endfunction

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] v, ps, es, t, t2;
        logic [1:0] pw;
        logic [15:0] l, r;
        logic [31:0] rd;
        logic er;
        int cr, cp;
        void'($urandom(1119));
        {reset_i, cyc, err_count, n_checks} = {1'b1, 32'd0, 32'd0, 32'd0};
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
        {rec_frame_i, play_frame_i, play_core_sel_i, play_core_pwr_cfg_i, rec_chan_pwr_i} = '0;
        {aif_strobe_i, aif_left_i, aif_right_i, vol_wclk_i, vol_tgt_left_i, vol_tgt_right_i} = '0;
        repeat (8) @(posedge ref_clk_i);
        reset_i <= 1'b0;
        rdchk("rec_sel", CDR_ADDR_REC_SEL, 32'h01);
        rdchk("core_cfg", CDR_ADDR_CORE_CFG, 32'h00);
        rdchk("play_setup", CDR_ADDR_PLAY_SETUP, 32'h14);
        chk("chan_pwr", 2'b00, {play_left_pwr_o, play_right_pwr_o});
        // every select code, reserved ones must leave the last legal code
        es = 8'h01;
        for (int c = 0; c < 32; c++) begin
            wr(CDR_ADDR_REC_SEL, 8'(c));
            es = (c <= 18) ? 8'(c) : es;
            rdchk("rec_sel", CDR_ADDR_REC_SEL, es);
            chk("rec_sel_o", es, rec_sel_o);
            chk("rec_core_en", es == 8'h00, rec_core_en_o);
        end
        // condition bits, reserved bits always read zero
        for (int k = 0; k < 8; k++) begin
            v = ((k == 0) ? 8'h77 : (k == 1) ? 8'h00 : 8'($urandom)) & CDR_CFG_RW_MASK;
            wr(CDR_ADDR_CORE_CFG, v);
            rdchk("core_cfg", CDR_ADDR_CORE_CFG, v & 8'h77);
            chk("rec_aux", {v[6], v[5]}, {rec_aux_a_o, rec_aux_b_o});
            chk("play_aux", {v[2], v[1]}, {play_aux_a_o, play_aux_b_o});
        end
        apb(1'b1, 12'h0F0, 32'h000000FF, rd, er);
        chk("slverr_wr", 1'b1, er);
        apb(1'b0, 12'h0F0, 32'h00000000, rd, er);
        chk("slverr_rd", 1'b1, er);
        chk("unmapped_rd", 32'h0, rd);
        // setup register, power bits and core power follow
        ps = 8'h14;
        for (int k = 0; k < 12; k++) begin
            v = (k == 0) ? 8'h01 : (k == 1) ? 8'hC0 : (k == 2) ? 8'h00 : 8'($urandom);
            v[1:0] = (v[1:0] == 2'b11) ? 2'b01 : v[1:0];
            @(posedge ref_clk_i);
            play_core_pwr_cfg_i <= (k > 2) && k[0];
            rec_chan_pwr_i <= 1'($urandom);
            wr(CDR_ADDR_PLAY_SETUP, v);
            ps = (v[1:0] == 2'b11) ? {v[7:2], ps[1:0]} : v;
            rdchk("play_setup", CDR_ADDR_PLAY_SETUP, ps);
            chk("chan_pwr", ps[7:6], {play_left_pwr_o, play_right_pwr_o});
            if (play_core_pwr_cfg_i === 1'b1) begin
                chk("core_pwr_rec", rec_chan_pwr_i, play_core_pwr_o);
            end else if (ps[7:6] == 2'b00 || ps[7:6] == 2'b11) begin
                chk("core_pwr", ps[7], play_core_pwr_o);
            end
        end
        // instruction counters, the two keep bits set apart
        @(posedge ref_clk_i);
        play_core_pwr_cfg_i <= 1'b0;
        play_core_sel_i <= 1'b1;
        wr(CDR_ADDR_REC_SEL, 8'h00);
        wr(CDR_ADDR_CORE_CFG, 8'h00);
        wr(CDR_ADDR_PLAY_SETUP, 8'hD6);
        pulse_frame();
        cr = cyc;
        cp = cyc;
        chk("rec_pc", 10'h000, rec_pc_o);
        chk("play_pc", 10'h000, play_pc_o);
        wr(CDR_ADDR_CORE_CFG, 8'h10);
        pulse_frame();
        chk("rec_pc", 10'(cyc - cr), rec_pc_o);
        chk("play_pc", 10'h000, play_pc_o);
        cp = cyc;
        wr(CDR_ADDR_CORE_CFG, 8'h01);
        pulse_frame();
        chk("rec_pc", 10'h000, rec_pc_o);
        chk("play_pc", 10'(cyc - cp), play_pc_o);
        wr(CDR_ADDR_REC_SEL, 8'h05);
        @(posedge ref_clk_i);
        #1;
        chk("rec_pc_idle", 10'h000, rec_pc_o);
        // every source code on both sides, full-scale mono corners
        for (int k = 0; k < 24; k++) begin
            pw = (k < 16) ? 2'b11 : 2'($urandom);
            wr(CDR_ADDR_PLAY_SETUP, {pw, 4'(k), 2'b10});
            l = (k == 15) ? 16'h7FFF : (k == 14) ? 16'h8000 : 16'($urandom);
            r = (k == 15) ? 16'h7FFF : (k == 14) ? 16'h8000 : 16'($urandom);
            @(posedge ref_clk_i);
            aif_strobe_i <= 1'b1;
            aif_left_i <= l;
            aif_right_i <= r;
            @(posedge ref_clk_i);
            aif_strobe_i <= 1'b0;
            aif_left_i <= ~l;
            aif_right_i <= ~r;
            #1;
            chk("play_left", exp_src(k[3:2], pw[1], l, r), $unsigned(play_left_o));
            chk("play_right", exp_src(k[1:0], pw[0], r, l), $unsigned(play_right_o));
        end
        // soft-step: immediate, one per word clock, one per two
        t = 8'($urandom_range(0, 40));
        t2 = 8'($urandom_range(0, 40)) - 8'd30;
        wr(CDR_ADDR_PLAY_SETUP, 8'hD6);
        @(posedge ref_clk_i);
        vol_tgt_left_i <= t;
        vol_tgt_right_i <= t2;
        repeat (2) @(posedge ref_clk_i);
        #1;
        chk("vol_left", t, $unsigned(vol_left_o));
        chk("vol_right", t2, $unsigned(vol_right_o));
        wr(CDR_ADDR_PLAY_SETUP, 8'hD4);
        @(posedge ref_clk_i);
        vol_tgt_left_i <= t + 8'd5;
        vol_tgt_right_i <= t2 - 8'd5;
        for (int k = 1; k < 3; k++) begin
            wclk();
            chk("vol_left", t + 8'(k), $unsigned(vol_left_o));
            chk("vol_right", 8'(t2 - 8'(k)), $unsigned(vol_right_o));
        end
        // pair of ticks gives one step whatever the internal phase
        wr(CDR_ADDR_PLAY_SETUP, 8'hD5);
        wclk();
        wclk();
        chk("vol_left", t + 8'd3, $unsigned(vol_left_o));
        chk("vol_right", 8'(t2 - 8'd3), $unsigned(vol_right_o));
        close_out();
    end
endmodule
`default_nettype wire
